// ### include/bsfr_defines.svh
`ifndef BSFR_DEFINES_SVH
`define BSFR_DEFINES_SVH

// ==========================================================
// field widths
`define BSFR_BEAM_W     15
`define BSFR_SECT_W     12
`define BSFR_IQ_W       16
`define BSFR_SEQ_W      8
`define BSFR_HDR_W      32
`define BSFR_PCID_W     16
`define BSFR_PRB_W      10
`define BSFR_NPRB_W     8

// ==========================================================
// reset values and counter width
`define BSFR_BEAM_NONE  15'h0000
`define BSFR_SEQ_RST    8'h00
`define BSFR_CNT_RST    16'h0000
`define BSFR_CNT_W      16

`endif

// ### include/bsfr_pkg.sv
`include "bsfr_defines.svh"

package bsfr_pkg;

    // ==========================================================
    // downlink section beat from the distributed unit
    typedef struct packed {
        logic                      cPlane;
        logic                      sop;
        logic                      eop;
        logic [`BSFR_HDR_W-1:0]    commonHdr;
        logic [`BSFR_SECT_W-1:0]   sectionId;
        logic [`BSFR_BEAM_W-1:0]   beamId;
        logic [31:0]               data;
    } bsfr_dl_sect_t;

    // downlink section beat toward one radio unit
    typedef struct packed {
        logic                      hdrStart;
        logic                      cPlane;
        logic                      eop;
        logic [`BSFR_HDR_W-1:0]    commonHdr;
        logic [`BSFR_SECT_W-1:0]   sectionId;
        logic [`BSFR_BEAM_W-1:0]   beamId;
        logic [31:0]               data;
    } bsfr_ru_sect_t;

    // ==========================================================
    // identity of one uplink resource element
    typedef struct packed {
        logic [`BSFR_PCID_W-1:0]   pcid;
        logic                      dir;
        logic [7:0]                frame;
        logic [3:0]                subframe;
        logic [5:0]                slot;
        logic [5:0]                symbol;
        logic                      rb;
        logic                      symInc;
        logic [`BSFR_PRB_W-1:0]    startPrb;
        logic [`BSFR_NPRB_W-1:0]   numPrb;
    } bsfr_ul_key_t;

    typedef struct packed {
        logic                      sop;
        logic                      eop;
        logic [`BSFR_HDR_W-1:0]    tpHdr;
        bsfr_ul_key_t              key;
        logic [`BSFR_IQ_W-1:0]     iSamp;
        logic [`BSFR_IQ_W-1:0]     qSamp;
    } bsfr_ul_beat_t;

    typedef struct packed {
        logic                      hdrStart;
        logic                      eop;
        logic [`BSFR_SEQ_W-1:0]    seqId;
        logic [`BSFR_HDR_W-1:0]    tpHdr;
        bsfr_ul_key_t              key;
        logic [`BSFR_IQ_W-1:0]     iSamp;
        logic [`BSFR_IQ_W-1:0]     qSamp;
    } bsfr_nb_beat_t;

    typedef enum logic [0:0] {
        UL_IDLE = 1'b0,
        UL_BODY = 1'b1
    } bsfr_ul_state_t;

endpackage : bsfr_pkg

// ### design/bsfr_router.sv
`timescale 1ns/1ns
`include "bsfr_defines.svh"
// Behaviour
// - split control sections by their beam
// - split user sections via section-to-beam map
// - per-beam messages, user plane gets header
// - send only to radio units mapped
// - control beam field becomes local beam
// - lone contributor passes through unchanged
// - one common header per northbound message
// - own sequence id, other header fields copied
// - global beam zero never accepted
// - table loaded before selective operation
// - separate beams: route and translate only
// - common beam: duplicate down, combine up
// - match on all resource element fields
// - clamp overflow, keep sample format
module bsfr_router #(
    parameter int NRU   = 4,
    parameter int NBEAM = 16,
    parameter int SECTN = 64
) (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic                             ce,
    // table loading and control
    input  wire logic                             cfgWe,
    input  wire logic [$clog2(NBEAM)-1:0]         cfgIdx,
    input  wire logic [`BSFR_BEAM_W-1:0]          cfgGlobal,
    input  wire logic [NRU-1:0]                   cfgRuMask,
    input  wire logic [NRU-1:0][`BSFR_BEAM_W-1:0] cfgLocal,
    input  wire logic                             cfgDone,
    input  wire logic                             selEnable,
    output logic                                  selCapable,
    output logic                                  selActive,
    output logic [`BSFR_CNT_W-1:0]                dropCount,
    // downlink north
    input  wire logic                             dlValid,
    output logic                                  dlReady,
    input  wire bsfr_pkg::bsfr_dl_sect_t          dlIn,
    // downlink south
    output logic [NRU-1:0]                        ruValid,
    input  wire logic [NRU-1:0]                   ruReady,
    output bsfr_pkg::bsfr_ru_sect_t               ruOut [NRU],
    // uplink south
    input  wire logic [NRU-1:0]                   ulValid,
    output logic [NRU-1:0]                        ulReady,
    input  wire bsfr_pkg::bsfr_ul_beat_t          ulIn [NRU],
    // uplink north
    output logic                                  nbValid,
    input  wire logic                             nbReady,
    output bsfr_pkg::bsfr_nb_beat_t               nbOut
);
    import bsfr_pkg::*;

    localparam int BIW = $clog2(NBEAM);
    localparam int SIW = $clog2(SECTN);
    localparam int AW  = `BSFR_IQ_W + $clog2(NRU) + 1;

    // ==========================================================
    // mapping table
    logic [NBEAM-1:0]                        tabValid_r, tabValid_nxt;
    logic [`BSFR_BEAM_W-1:0]                 tabGlobal_r [NBEAM];
    logic [`BSFR_BEAM_W-1:0]                 tabGlobal_nxt [NBEAM];
    logic [NRU-1:0]                          tabMask_r [NBEAM];
    logic [NRU-1:0]                          tabMask_nxt [NBEAM];
    logic [NRU-1:0][`BSFR_BEAM_W-1:0]        tabLocal_r [NBEAM];
    logic [NRU-1:0][`BSFR_BEAM_W-1:0]        tabLocal_nxt [NBEAM];
    logic                                    loaded_r, loaded_nxt;

    always_comb
    begin
        tabValid_nxt  = tabValid_r;
        tabGlobal_nxt = tabGlobal_r;
        tabMask_nxt   = tabMask_r;
        tabLocal_nxt  = tabLocal_r;
        loaded_nxt    = loaded_r || cfgDone;
        // a zero global beam is written with its valid bit clear, so it never matches
        if (cfgWe)
        begin
            tabValid_nxt[cfgIdx]  = (cfgGlobal != `BSFR_BEAM_NONE);
            tabGlobal_nxt[cfgIdx] = cfgGlobal;
            tabMask_nxt[cfgIdx]   = cfgRuMask;
            tabLocal_nxt[cfgIdx]  = cfgLocal;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tabValid_r <= '0;
            loaded_r   <= 1'b0;
            for (int b = 0; b < NBEAM; b++)
            begin
                tabGlobal_r[b] <= `BSFR_BEAM_NONE;
                tabMask_r[b]   <= '0;
                tabLocal_r[b]  <= '0;
            end
        end
        else if (ce)
        begin
            tabValid_r  <= tabValid_nxt;
            tabGlobal_r <= tabGlobal_nxt;
            tabMask_r   <= tabMask_nxt;
            tabLocal_r  <= tabLocal_nxt;
            loaded_r    <= loaded_nxt;
        end
    end

    assign selCapable = 1'b1;
    assign selActive  = selEnable && loaded_r;

    // ==========================================================
    // downlink split, route and translate
    logic [`BSFR_BEAM_W-1:0]  sectBeam_r [SECTN];
    logic [`BSFR_BEAM_W-1:0]  sectBeam_nxt [SECTN];
    logic [`BSFR_BEAM_W-1:0]  ruBeam_r [NRU];
    logic [`BSFR_BEAM_W-1:0]  ruBeam_nxt [NRU];
    logic [NRU-1:0]           ruValid_r, ruValid_nxt;
    bsfr_ru_sect_t            ruOut_r [NRU];
    bsfr_ru_sect_t            ruOut_nxt [NRU];
    logic [`BSFR_CNT_W-1:0]   drop_r, drop_nxt;
    logic [`BSFR_BEAM_W-1:0]  dlBeam;
    logic                     dlHit;
    logic [BIW-1:0]           dlIdx;
    logic                     dlTake;

    always_comb
    begin
        sectBeam_nxt = sectBeam_r;
        ruBeam_nxt   = ruBeam_r;
        ruOut_nxt    = ruOut_r;
        drop_nxt     = drop_r;
        dlHit        = 1'b0;
        dlIdx        = '0;
        dlReady      = 1'b1;
        // control sections carry the beam, user sections inherit it
        dlBeam = dlIn.cPlane ? dlIn.beamId : sectBeam_r[dlIn.sectionId[SIW-1:0]];
        for (int b = 0; b < NBEAM; b++)
        begin
            if (!dlHit && tabValid_r[b] && tabGlobal_r[b] == dlBeam)
            begin
                dlHit = 1'b1;
                dlIdx = b[BIW-1:0];
            end
        end
        // stall whole input until every stuck south port drains
        for (int r = 0; r < NRU; r++)
        begin
            ruValid_nxt[r] = ruValid_r[r] && !ruReady[r];
            if (ruValid_r[r] && !ruReady[r])
                dlReady = 1'b0;
        end
        dlTake = ce && dlValid && dlReady;
        if (dlTake && selActive)
        begin
            if (dlIn.cPlane)
                sectBeam_nxt[dlIn.sectionId[SIW-1:0]] = dlIn.beamId;
            if (!dlHit || dlBeam == `BSFR_BEAM_NONE)
                drop_nxt = drop_r + 1'b1;
            else
            begin
                for (int r = 0; r < NRU; r++)
                begin
                    if (tabMask_r[dlIdx][r])
                    begin
                        ruValid_nxt[r]        = 1'b1;
                        ruBeam_nxt[r]         = dlBeam;
                        ruOut_nxt[r].cPlane   = dlIn.cPlane;
                        ruOut_nxt[r].eop      = dlIn.eop;
                        ruOut_nxt[r].commonHdr = dlIn.commonHdr;
                        ruOut_nxt[r].sectionId = dlIn.sectionId;
                        ruOut_nxt[r].data     = dlIn.data;
                        // a new beam group opens a fresh user plane message
                        ruOut_nxt[r].hdrStart = !dlIn.cPlane && (dlIn.sop || ruBeam_r[r] != dlBeam);
                        ruOut_nxt[r].beamId   = dlIn.cPlane ? tabLocal_r[dlIdx][r] : dlIn.beamId;
                    end
                end
            end
        end
        else if (dlTake)
        begin
            // selective mode off: plain fan-out, untouched
            for (int r = 0; r < NRU; r++)
            begin
                ruValid_nxt[r]         = 1'b1;
                ruOut_nxt[r].hdrStart  = !dlIn.cPlane && dlIn.sop;
                ruOut_nxt[r].cPlane    = dlIn.cPlane;
                ruOut_nxt[r].eop       = dlIn.eop;
                ruOut_nxt[r].commonHdr = dlIn.commonHdr;
                ruOut_nxt[r].sectionId = dlIn.sectionId;
                ruOut_nxt[r].beamId    = dlIn.beamId;
                ruOut_nxt[r].data      = dlIn.data;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ruValid_r <= '0;
            drop_r    <= `BSFR_CNT_RST;
            for (int s = 0; s < SECTN; s++)
                sectBeam_r[s] <= `BSFR_BEAM_NONE;
            for (int r = 0; r < NRU; r++)
            begin
                ruBeam_r[r] <= `BSFR_BEAM_NONE;
                ruOut_r[r]  <= '0;
            end
        end
        else if (ce)
        begin
            ruValid_r  <= ruValid_nxt;
            drop_r     <= drop_nxt;
            sectBeam_r <= sectBeam_nxt;
            ruBeam_r   <= ruBeam_nxt;
            ruOut_r    <= ruOut_nxt;
        end
    end

    assign ruValid   = ruValid_r;
    assign ruOut     = ruOut_r;
    assign dropCount = drop_r;

    // ==========================================================
    // uplink combine and rebuild
    bsfr_ul_state_t           ulState_r, ulState_nxt;
    logic [`BSFR_SEQ_W-1:0]   seq_r, seq_nxt;
    logic                     nbValid_r, nbValid_nxt;
    bsfr_nb_beat_t            nbOut_r, nbOut_nxt;
    logic                     ulAny;
    logic [$clog2(NRU)-1:0]   lead;
    logic [NRU-1:0]           member;
    logic signed [AW-1:0]     sumI, sumQ;
    logic                     nbFree;

    function automatic logic [`BSFR_IQ_W-1:0] clampIq(input logic signed [AW-1:0] v);
        logic signed [AW-1:0] hi;
        logic signed [AW-1:0] lo;
        hi = AW'(signed'({1'b0, {(`BSFR_IQ_W-1){1'b1}}}));
        lo = -hi - AW'(1);
        if (v > hi)
            clampIq = {1'b0, {(`BSFR_IQ_W-1){1'b1}}};
        else if (v < lo)
            clampIq = {1'b1, {(`BSFR_IQ_W-1){1'b0}}};
        else
            clampIq = v[`BSFR_IQ_W-1:0];
    endfunction : clampIq

    always_comb
    begin
        ulState_nxt = ulState_r;
        seq_nxt     = seq_r;
        nbOut_nxt   = nbOut_r;
        ulAny       = 1'b0;
        lead        = '0;
        sumI        = '0;
        sumQ        = '0;
        nbFree      = !nbValid_r || nbReady;
        nbValid_nxt = nbValid_r && !nbReady;
        for (int r = NRU - 1; r >= 0; r--)
        begin
            if (ulValid[r])
            begin
                ulAny = 1'b1;
                lead  = r[$clog2(NRU)-1:0];
            end
        end
        // samples belong together only when the full identity agrees
        for (int r = 0; r < NRU; r++)
        begin
            member[r]  = ulValid[r] && ulIn[r].key == ulIn[lead].key;
            ulReady[r] = member[r] && nbFree && ce;
            if (member[r])
            begin
                sumI = sumI + AW'(signed'(ulIn[r].iSamp));
                sumQ = sumQ + AW'(signed'(ulIn[r].qSamp));
            end
        end
        if (ce && ulAny && nbFree)
        begin
            nbValid_nxt       = 1'b1;
            nbOut_nxt.hdrStart = (ulState_r == UL_IDLE);
            nbOut_nxt.eop     = ulIn[lead].eop;
            nbOut_nxt.seqId   = seq_r;
            nbOut_nxt.tpHdr   = ulIn[lead].tpHdr;
            nbOut_nxt.key     = ulIn[lead].key;
            // width and format unchanged; out of range sums saturate
            nbOut_nxt.iSamp   = clampIq(sumI);
            nbOut_nxt.qSamp   = clampIq(sumQ);
            if (ulState_r == UL_IDLE)
                seq_nxt = seq_r + 1'b1;
            case (ulState_r)
                UL_IDLE: ulState_nxt = ulIn[lead].eop ? UL_IDLE : UL_BODY;
                UL_BODY: ulState_nxt = ulIn[lead].eop ? UL_IDLE : UL_BODY;
                default: ulState_nxt = UL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ulState_r <= UL_IDLE;
            seq_r     <= `BSFR_SEQ_RST;
            nbValid_r <= 1'b0;
            nbOut_r   <= '0;
        end
        else if (ce)
        begin
            ulState_r <= ulState_nxt;
            seq_r     <= seq_nxt;
            nbValid_r <= nbValid_nxt;
            nbOut_r   <= nbOut_nxt;
        end
    end

    assign nbValid = nbValid_r;
    assign nbOut   = nbOut_r;

endmodule : bsfr_router

// ### tb/bsfr_router_sva.sv
`timescale 1ns/1ns
`include "bsfr_defines.svh"
module bsfr_router_sva #(
    parameter int NRU = 4
) (
    input wire logic                     clk,
    input wire logic                     rst,
    input wire logic                     ce,
    input wire logic                     selEnable,
    input wire logic                     selCapable,
    input wire logic                     selActive,
    input wire logic [`BSFR_CNT_W-1:0]   dropCount,
    input wire logic                     dlValid,
    input wire logic                     dlReady,
    input wire bsfr_pkg::bsfr_dl_sect_t  dlIn,
    input wire logic [NRU-1:0]           ruValid,
    input wire logic [NRU-1:0]           ruReady,
    input wire bsfr_pkg::bsfr_ru_sect_t  ruOut [NRU],
    input wire logic [NRU-1:0]           ulValid,
    input wire logic [NRU-1:0]           ulReady,
    input wire logic                     nbValid,
    input wire logic                     nbReady,
    input wire bsfr_pkg::bsfr_nb_beat_t  nbOut
);
    import bsfr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ====
    // checks
    reset_clear_a: assert property ($fell(rst) |-> ruValid == '0 && !nbValid && dropCount == '0 && !selActive)
        else $error("state not cleared by reset");
    cap_const_a: assert property (selCapable)
        else $error("capability not advertised");
    sel_gate_a: assert property (selActive |-> selEnable)
        else $error("selective mode active without enable");
    dl_block_a: assert property ((ruValid & ~ruReady) != '0 |-> !dlReady)
        else $error("downlink accepted while a south slot is blocked");
    ru_hold_a: assert property (ruValid[0] && !ruReady[0] |=> ruValid[0] && $stable(ruOut[0]))
        else $error("south beat changed before acceptance");
    dl_answer_a: assert property (ce && dlValid && dlReady && dlIn.cPlane |=> ruValid != '0 || dropCount != $past(dropCount))
        else $error("taken control beat neither routed nor counted");
    drop_count_a: assert property (ce && dlValid && dlReady && selActive && dlIn.cPlane && dlIn.beamId == '0
        |=> dropCount == $past(dropCount) + 1'b1 && ruValid == '0)
        else $error("beam zero section not dropped and counted");
    ul_ready_a: assert property ((ulReady & ~ulValid) == '0 && (ce || ulReady == '0))
        else $error("uplink ready without valid or enable");
    ul_lead_a: assert property (ce && ulValid != '0 && (!nbValid || nbReady)
        |-> (ulReady & ulValid & (~ulValid + 1'b1)) != '0)
        else $error("lowest valid unit not taken");
    nb_answer_a: assert property (ce && ulValid != '0 && (!nbValid || nbReady) |=> nbValid)
        else $error("no northbound beat after uplink take");
    nb_hold_a: assert property (nbValid && !nbReady |=> nbValid && $stable(nbOut))
        else $error("northbound beat changed before acceptance");
    cover property (ce && dlValid && dlReady && dlIn.cPlane);
    cover property (ruValid[0] && !ruReady[0]);
    cover property (nbValid && nbOut.hdrStart);
endmodule : bsfr_router_sva

bind bsfr_router bsfr_router_sva #(.NRU(NRU)) u_bsfr_router_sva (
    .clk(clk), .rst(rst), .ce(ce), .selEnable(selEnable), .selCapable(selCapable), .selActive(selActive),
    .dropCount(dropCount), .dlValid(dlValid), .dlReady(dlReady), .dlIn(dlIn), .ruValid(ruValid),
    .ruReady(ruReady), .ruOut(ruOut), .ulValid(ulValid), .ulReady(ulReady), .nbValid(nbValid),
    .nbReady(nbReady), .nbOut(nbOut)
);

// ### tb/bsfr_ru_model.sv
`timescale 1ns/1ns
`include "bsfr_defines.svh"
module bsfr_ru_model #(
    parameter int NRU = 4
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         slow,
    input  wire logic [NRU-1:0]               ruValid,
    output logic [NRU-1:0]                    ruReady,
    input  wire bsfr_pkg::bsfr_ru_sect_t      ruOut [NRU],
    output logic [NRU-1:0][`BSFR_BEAM_W-1:0]  gotBeam
);
    import bsfr_pkg::*;
    logic [1:0] cnt;
    // ====
    // slow units take one beat in four, so the hub must hold its beats
    assign ruReady = (slow && cnt != 2'h3) ? '0 : '1;
    always_ff @(posedge clk)
    begin
        cnt <= rst ? 2'h0 : cnt + 2'h1;
        for (int u = 0; u < NRU; u++)
        begin
            if (rst)
                gotBeam[u] <= '0;
            else if (ruValid[u] && ruReady[u] && ruOut[u].cPlane)
                gotBeam[u] <= ruOut[u].beamId;
        end
    end
endmodule : bsfr_ru_model

// ### tb/testbench.sv
`timescale 1ns/1ns
`include "bsfr_defines.svh"
module testbench;
    import bsfr_pkg::*;
    localparam int NRU = 4;
    typedef struct packed {
        logic                     cPlane;
        logic [`BSFR_SECT_W-1:0]  sect;
        logic [`BSFR_BEAM_W-1:0]  beam;
        logic [NRU-1:0]           mask;
    } bsfr_tb_row_t;
    logic                              clk, rst, ce, cfgWe, cfgDone, selEnable, selCapable, selActive;
    logic                              dlValid, dlReady, nbValid, nbReady, slow;
    logic [3:0]                        cfgIdx;
    logic [`BSFR_BEAM_W-1:0]           cfgGlobal;
    logic [NRU-1:0]                    cfgRuMask, ruValid, ruReady, ulValid, ulReady;
    logic [NRU-1:0][`BSFR_BEAM_W-1:0]  cfgLocal, gotBeam;
    logic [`BSFR_CNT_W-1:0]            dropCount, expDrop;
    bsfr_dl_sect_t                     dlIn;
    bsfr_ru_sect_t                     ruOut [NRU];
    bsfr_ul_beat_t                     ulIn [NRU];
    bsfr_nb_beat_t                     nbOut;
    bsfr_ul_key_t                      key;
    int                                n_mismatch, cmp_count;
    bsfr_tb_row_t rows [6] = '{'{1'b1, 12'h001, 15'h0005, 4'h1}, '{1'b1, 12'h002, 15'h0007, 4'h6},
        '{1'b0, 12'h001, 15'h0005, 4'h1}, '{1'b0, 12'h002, 15'h0007, 4'h6},
        '{1'b1, 12'h003, 15'h0009, 4'h0}, '{1'b1, 12'h004, 15'h0000, 4'h0}};

    bsfr_router u_bsfr_router (.clk(clk), .rst(rst), .ce(ce), .cfgWe(cfgWe), .cfgIdx(cfgIdx),
        .cfgGlobal(cfgGlobal), .cfgRuMask(cfgRuMask), .cfgLocal(cfgLocal), .cfgDone(cfgDone),
        .selEnable(selEnable), .selCapable(selCapable), .selActive(selActive), .dropCount(dropCount),
        .dlValid(dlValid), .dlReady(dlReady), .dlIn(dlIn), .ruValid(ruValid), .ruReady(ruReady),
        .ruOut(ruOut), .ulValid(ulValid), .ulReady(ulReady), .ulIn(ulIn), .nbValid(nbValid),
        .nbReady(nbReady), .nbOut(nbOut));
    bsfr_ru_model u_bsfr_ru_model (.clk(clk), .rst(rst), .slow(slow), .ruValid(ruValid),
        .ruReady(ruReady), .ruOut(ruOut), .gotBeam(gotBeam));

    // ====
    // helpers
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    // local beams stay distinct within each unit
    function automatic logic [`BSFR_BEAM_W-1:0] locOf(logic [`BSFR_BEAM_W-1:0] g, int u);
        if (g == 15'h0005)
            return 15'h0003;
        return (u == 1) ? 15'h0009 : 15'h000B;
    endfunction : locOf

    task automatic cfgWrite(logic [3:0] idx, logic [`BSFR_BEAM_W-1:0] g, logic [NRU-1:0] m);
        @(negedge clk);
        cfgWe = 1'b1;
        cfgIdx = idx;
        cfgGlobal = g;
        cfgRuMask = m;
        for (int u = 0; u < NRU; u++)
            cfgLocal[u] = locOf(g, u);
        @(negedge clk);
        cfgWe = 1'b0;
    endtask : cfgWrite

    task automatic sendDl(bsfr_tb_row_t r);
        int w;
        @(negedge clk);
        dlValid = 1'b1;
        dlIn = '{cPlane: r.cPlane, sop: 1'b1, eop: 1'b1, commonHdr: 32'hA5A50001, sectionId: r.sect,
                 beamId: r.beam, data: 32'h12345678};
        w = 0;
        while (dlReady !== 1'b1 && w < 50)
        begin
            @(negedge clk);
            w++;
        end
        if (w >= 50)
            n_mismatch++;
        @(negedge clk);
        dlValid = 1'b0;
    endtask : sendDl

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        #40000;
        n_mismatch++;
        results();
    end

    initial
    begin
        {rst, ce, cfgWe, cfgDone, selEnable, dlValid, nbReady, slow} = 8'hC2;
        {cfgIdx, cfgGlobal, cfgRuMask, cfgLocal, dlIn, ulValid, key} = '0;
        foreach (ulIn[u])
            ulIn[u] = '0;
        n_mismatch = 0;
        cmp_count = 0;
        expDrop = '0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        check("selCapable", selCapable, 1'b1);
        selEnable = 1'b1;
        sendDl(rows[0]);
        check("selActive", selActive, 1'b0);
        check("broadcast", ruValid, 4'hF);
        cfgWrite(4'h0, 15'h0005, 4'h1);
        cfgWrite(4'h1, 15'h0007, 4'h6);
        cfgWrite(4'h2, 15'h0000, 4'hF);
        cfgDone = 1'b1;
        @(negedge clk);
        cfgDone = 1'b0;
        check("selActive", selActive, 1'b1);
        foreach (rows[i])
        begin
            sendDl(rows[i]);
            expDrop = expDrop + (rows[i].mask == '0);
            check("ruValid", ruValid, rows[i].mask);
            check("dropCount", dropCount, expDrop);
            for (int u = 0; u < NRU; u++)
                if (rows[i].mask[u])
                    check("beamId", ruOut[u].beamId, rows[i].cPlane ? locOf(rows[i].beam, u) : rows[i].beam);
            for (int u = 0; u < NRU; u++)
                if (rows[i].mask[u])
                    check("hdrStart", ruOut[u].hdrStart, !rows[i].cPlane);
        end
        slow = 1'b1;
        sendDl('{1'b1, 12'h005, 15'h0007, 4'h6});
        check("ruValid", ruValid, 4'h6);
        check("dlReady", dlReady, (ruValid & ~ruReady) == '0);
        sendDl('{1'b1, 12'h006, 15'h0005, 4'h1});
        repeat (8) @(negedge clk);
        slow = 1'b0;
        check("gotBeam1", gotBeam[1], 15'h0009);
        check("gotBeam0", gotBeam[0], 15'h0003);
        key = '{16'h0001, 1'b0, 8'h01, 4'h2, 6'h03, 6'h04, 1'b0, 1'b0, 10'h000, 8'h0C};
        ulIn[0] = '{1'b1, 1'b1, 32'h10000011, key, 16'h7000, 16'h0010};
        ulIn[1] = '{1'b1, 1'b1, 32'h20000022, key, 16'h2000, 16'h0020};
        ulIn[2] = '{1'b1, 1'b1, 32'h30000033, key, 16'h1234, 16'hFFF0};
        key.symbol = 6'h05;
        ulIn[3] = '{1'b1, 1'b1, 32'h40000044, key, 16'h0555, 16'h0666};
        ce = 1'b0;
        ulValid = 4'h3;
        @(negedge clk);
        check("ulReady", ulReady, 4'h0);
        ce = 1'b1;
        #1;
        check("ulReady", ulReady, 4'h3);
        @(negedge clk);
        ulValid = 4'hC;
        check("nbValid", nbValid, 1'b1);
        check("iSamp", nbOut.iSamp, 16'h7FFF);
        check("qSamp", nbOut.qSamp, 16'h0030);
        check("hdrStart", nbOut.hdrStart, 1'b1);
        check("seqId", nbOut.seqId, 8'h00);
        check("tpHdr", nbOut.tpHdr, 32'h10000011);
        #1;
        check("ulReady", ulReady, 4'h4);
        @(negedge clk);
        ulValid = 4'h8;
        check("iSamp", nbOut.iSamp, 16'h1234);
        check("seqId", nbOut.seqId, 8'h01);
        @(negedge clk);
        ulValid = 4'h0;
        check("iSamp", nbOut.iSamp, 16'h0555);
        check("seqId", nbOut.seqId, 8'h02);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        check("dropCount", dropCount, 16'h0000);
        check("selActive", selActive, 1'b0);
        results();
    end
endmodule : testbench
